// >>> aac_consts.vh
// Constants shared by the converter alert and power control block.
`ifndef AAC_CONSTS_VH
`define AAC_CONSTS_VH

// Register word addresses on the Avalon-MM slave.
`define AAC_ADDR_RESULT    6'h00
`define AAC_ADDR_CHSEL     6'h01
`define AAC_ADDR_CONFIG    6'h02
`define AAC_ADDR_ALERT     6'h03
`define AAC_ADDR_STATUS    6'h04
`define AAC_ADDR_HI_BASE   6'h08
`define AAC_ADDR_LO_BASE   6'h0C
`define AAC_ADDR_HYST_BASE 6'h10

// Configuration register field positions.
`define AAC_CFG_REF    0
`define AAC_CFG_SLEEP  1
`define AAC_CFG_POL    3
`define AAC_CFG_AEN    4
`define AAC_CFG_BUSY   5
`define AAC_CFG_DRIVE  6
`define AAC_CFG_LATCH  7
`define AAC_CFG_SWRST  9

// Reset values.
`define AAC_CFG_RESET   10'h000
`define AAC_HI_RESET    9'h1FF
`define AAC_LO_RESET    9'h000
`define AAC_HYST_RESET  9'h1FF
`define AAC_CHSEL_RESET 2'h0

// Timing, in nanoseconds at the printed figures, and derived cycle counts.
`define AAC_CLK_MHZ       100
`define AAC_CONV_TIME_NS  600
`define AAC_PULSE_GAP_NS  2000
`define AAC_PWRUP_TIME_NS 1000
`define AAC_CONV_CYC      ((`AAC_CONV_TIME_NS * `AAC_CLK_MHZ) / 1000)
`define AAC_GAP_CYC       ((`AAC_PULSE_GAP_NS * `AAC_CLK_MHZ + 999) / 1000)
`define AAC_PWRUP_CYC     ((`AAC_PWRUP_TIME_NS * `AAC_CLK_MHZ) / 1000)
`define AAC_INIT_PULSES   66

`endif

// >>> aac_chan_alert.v
// Per-channel upper and lower bound alert flags with hysteresis and latching.
`timescale 1ns/1ps
module aac_chan_alert (
  input  wire       mclk_in,
  input  wire       rst_in,
  input  wire       ce_in,
  input  wire       eval_in,
  input  wire [8:0] value_in,
  input  wire [8:0] upper_in,
  input  wire [8:0] lower_in,
  input  wire [8:0] hyst_in,
  input  wire       latch_in,
  input  wire       clear_in,
  output reg        hi_flag_out,
  output reg        lo_flag_out
);
  reg        hi_sticky_reg;
  reg        lo_sticky_reg;
  wire       hi_set;
  wire       lo_set;
  wire       hi_release;
  wire       lo_release;
  wire [9:0] hi_thresh;
  wire [9:0] lo_thresh;

  // Thresholds kept one bit wider so the sum cannot wrap and an underflowed difference shows in the top bit.
  assign hi_thresh  = {1'b0, upper_in} - {1'b0, hyst_in};
  assign lo_thresh  = {1'b0, lower_in} + {1'b0, hyst_in};
  assign hi_set     = eval_in && (value_in > upper_in);
  assign lo_set     = eval_in && (value_in < lower_in);
  // An underflowed upper threshold can never be crossed, so the flag then waits for a read.
  assign hi_release = eval_in && !hi_thresh[9] && ({1'b0, value_in} < hi_thresh);
  assign lo_release = eval_in && ({1'b0, value_in} > lo_thresh);

  // A new violation beats a clear in the same cycle so no event is lost.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      hi_flag_out   <= 1'b0;
      lo_flag_out   <= 1'b0;
      hi_sticky_reg <= 1'b0;
      lo_sticky_reg <= 1'b0;
    end else if (ce_in) begin
      if (hi_set) begin
        hi_flag_out   <= 1'b1;
        hi_sticky_reg <= latch_in;
      end else if (clear_in) begin
        hi_flag_out <= 1'b0;
      end else if (hi_release && !hi_sticky_reg) begin
        hi_flag_out <= 1'b0;
      end
      if (lo_set) begin
        lo_flag_out   <= 1'b1;
        lo_sticky_reg <= latch_in;
      end else if (clear_in) begin
        lo_flag_out <= 1'b0;
      end else if (lo_release && !lo_sticky_reg) begin
        lo_flag_out <= 1'b0;
      end
    end
  end
endmodule // aac_chan_alert

// >>> aac_top.v
// Converter control: pulse-train initialization, power modes, alert detection and result shift-out.
//
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`include "aac_consts.vh"

module aac_top (
  input  wire        mclk_in,
  input  wire        rst_in,
  input  wire        clk_en_in,
  input  wire        conversion_start_n_in,
  input  wire [11:0] sample_data_in,
  input  wire        sclk_in,
  input  wire        cs_n_in,
  input  wire [5:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output wire        avs_waitrequest_out,
  output reg  [1:0]  sample_chan_out,
  output reg         analog_power_out,
  output reg         ref_power_out,
  output reg         init_done_out,
  output reg         conv_busy_out,
  output reg         sdo_out,
  output reg         sdo_oe_n_out,
  output reg         multi_function_output_pin_out,
  output reg         multi_function_output_pin_oe_n_out
);
  localparam NCH = 4;
  localparam CONV_CYC  = `AAC_CONV_CYC; // Unsized, so the counts compare at full width.
  localparam GAP_CYC   = `AAC_GAP_CYC;
  localparam PWRUP_CYC = `AAC_PWRUP_CYC;
  localparam INIT_CNT  = `AAC_INIT_PULSES;
  // Analog power states.
  localparam [1:0] PS_OFF  = 2'b00;
  localparam [1:0] PS_WAKE = 2'b01;
  localparam [1:0] PS_ON   = 2'b10;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  reg        cnv_s1_reg;
  reg        cnv_s2_reg;
  reg        cnv_s3_reg;
  reg        sclk_s1_reg;
  reg        sclk_s2_reg;
  reg        sclk_s3_reg;
  reg        cs_s1_reg;
  reg        cs_s2_reg;
  reg        cs_s3_reg;
  wire       cnv_fall;
  wire       cnv_rise;
  wire       sclk_fall;
  wire       cs_fall;
  // Edges are found between the second and third stages only.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      cnv_s1_reg  <= 1'b1;
      cnv_s2_reg  <= 1'b1;
      cnv_s3_reg  <= 1'b1;
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      cs_s1_reg   <= 1'b1;
      cs_s2_reg   <= 1'b1;
      cs_s3_reg   <= 1'b1;
    end else if (clk_en_in) begin
      cnv_s1_reg  <= conversion_start_n_in;
      cnv_s2_reg  <= cnv_s1_reg;
      cnv_s3_reg  <= cnv_s2_reg;
      sclk_s1_reg <= sclk_in;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      cs_s1_reg   <= cs_n_in;
      cs_s2_reg   <= cs_s1_reg;
      cs_s3_reg   <= cs_s2_reg;
    end
  end
  assign cnv_fall  = cnv_s3_reg && !cnv_s2_reg;
  assign cnv_rise  = !cnv_s3_reg && cnv_s2_reg;
  assign sclk_fall = sclk_s3_reg && !sclk_s2_reg;
  assign cs_fall   = cs_s3_reg && !cs_s2_reg;

  // ***************************************************************
  // Register file and Avalon-MM slave
  // ***************************************************************
  reg  [9:0]  cfg_reg;
  reg  [1:0]  chsel_reg;
  reg  [8:0]  hi_reg [0:NCH-1];
  reg  [8:0]  lo_reg [0:NCH-1];
  reg  [8:0]  hyst_reg [0:NCH-1];
  reg  [14:0] result_reg;
  reg         ack_reg;
  reg  [31:0] rdata_next;
  wire        bus_req;
  wire        wr_take;
  wire        rd_take;
  wire        swrst;
  wire        alert_rd_clr;
  wire [2*NCH-1:0] alert_flags;
  wire        alert_any;
  wire [15:0] result_word;
  integer     i;
  // Every access waits exactly one enabled cycle; the answer comes on the second enabled edge.
  assign bus_req             = avs_read_in || avs_write_in;
  assign avs_waitrequest_out = bus_req && !(ack_reg && clk_en_in); // Stays high while frozen.
  assign wr_take             = avs_write_in && ack_reg && clk_en_in;
  assign rd_take             = avs_read_in && ack_reg && clk_en_in;
  assign swrst               = wr_take && (avs_address_in == `AAC_ADDR_CONFIG)
                               && avs_writedata_in[`AAC_CFG_SWRST];
  assign alert_rd_clr        = (rd_take && (avs_address_in == `AAC_ADDR_ALERT)) || swrst;
  assign alert_any           = |alert_flags;
  assign result_word         = {result_reg[14:12], alert_any, result_reg[11:0]};
  // Read data mux; unmapped addresses read zero.
  always @* begin
    rdata_next = 32'h0000_0000;
    case (avs_address_in)
      `AAC_ADDR_RESULT: rdata_next[15:0] = result_word;
      `AAC_ADDR_CHSEL:  rdata_next[1:0]  = chsel_reg;
      `AAC_ADDR_CONFIG: rdata_next[9:0]  = cfg_reg;
      `AAC_ADDR_ALERT:  rdata_next[2*NCH-1:0] = alert_flags;
      `AAC_ADDR_STATUS: rdata_next[3:0] = {conv_busy_out, ref_power_out, analog_power_out, init_done_out};
      default: begin
        if (avs_address_in[5:2] == `AAC_ADDR_HI_BASE >> 2) begin
          rdata_next[8:0] = hi_reg[avs_address_in[1:0]];
        end else if (avs_address_in[5:2] == `AAC_ADDR_LO_BASE >> 2) begin
          rdata_next[8:0] = lo_reg[avs_address_in[1:0]];
        end else if (avs_address_in[5:2] == `AAC_ADDR_HYST_BASE >> 2) begin
          rdata_next[8:0] = hyst_reg[avs_address_in[1:0]];
        end
      end
    endcase
  end
  // Bus handshake, read data capture and register writes.
  // The register file and the serial output stay live in every power state.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_reg          <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
      cfg_reg          <= `AAC_CFG_RESET;
      chsel_reg        <= `AAC_CHSEL_RESET;
      for (i = 0; i < NCH; i = i + 1) begin
        hi_reg[i]   <= `AAC_HI_RESET;
        lo_reg[i]   <= `AAC_LO_RESET;
        hyst_reg[i] <= `AAC_HYST_RESET;
      end
    end else if (clk_en_in) begin
      ack_reg <= bus_req && !ack_reg;
      if (bus_req && !ack_reg) begin
        avs_readdata_out <= rdata_next;
      end
      if (wr_take) begin
        case (avs_address_in)
          `AAC_ADDR_CHSEL:  chsel_reg <= avs_writedata_in[1:0];
          `AAC_ADDR_CONFIG: cfg_reg <= {1'b0, avs_writedata_in[8:0]}; // software reset bit self-clears
          default: begin
            if (avs_address_in[5:2] == `AAC_ADDR_HI_BASE >> 2) begin
              hi_reg[avs_address_in[1:0]] <= avs_writedata_in[8:0];
            end else if (avs_address_in[5:2] == `AAC_ADDR_LO_BASE >> 2) begin
              lo_reg[avs_address_in[1:0]] <= avs_writedata_in[8:0];
            end else if (avs_address_in[5:2] == `AAC_ADDR_HYST_BASE >> 2) begin
              hyst_reg[avs_address_in[1:0]] <= avs_writedata_in[8:0];
            end
          end
        endcase
      end
    end
  end

  // ***************************************************************
  // Pulse-train initialization
  // ***************************************************************
  reg [6:0] init_cnt_reg;
  reg [7:0] gap_cnt_reg;
  // A pulse counts at its rising end, and only once the gap since the last counted pulse is long enough.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      init_cnt_reg  <= 7'h00;
      gap_cnt_reg   <= 8'hFF;
      init_done_out <= 1'b0;
    end else if (clk_en_in) begin
      if (gap_cnt_reg != 8'hFF) begin
        gap_cnt_reg <= gap_cnt_reg + 8'h01;
      end
      if (!init_done_out && cnv_rise && (gap_cnt_reg >= GAP_CYC)) begin
        gap_cnt_reg  <= 8'h01;
        init_cnt_reg <= init_cnt_reg + 7'h01;
        if (init_cnt_reg == INIT_CNT - 7'h01) begin
          init_done_out <= 1'b1;
        end
      end
    end
  end

  // ***************************************************************
  // Conversion timing and power modes
  // ***************************************************************
  reg  [1:0] pstate_reg;
  reg  [7:0] conv_cnt_reg;
  reg  [7:0] wake_cnt_reg;
  wire       eoc;
  assign eoc = conv_busy_out && (conv_cnt_reg == CONV_CYC - 8'h01);
  // Conversions start only once initialized and fully powered.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      conv_busy_out   <= 1'b0;
      conv_cnt_reg    <= 8'h00;
      result_reg      <= 15'h0000;
      sample_chan_out <= 2'h0;
    end else if (clk_en_in) begin
      if (swrst) begin
        result_reg <= 15'h0000;
      end
      if (!conv_busy_out) begin
        sample_chan_out <= chsel_reg;
        if (cnv_fall && init_done_out && (pstate_reg == PS_ON)) begin
          conv_busy_out <= 1'b1;
          conv_cnt_reg  <= 8'h00;
        end
      end else if (eoc) begin
        conv_busy_out <= 1'b0;
        result_reg    <= {1'b0, sample_chan_out, sample_data_in};
      end else begin
        conv_cnt_reg <= conv_cnt_reg + 8'h01;
      end
    end
  end
  // Power state: the start-pin level at end of conversion keeps or drops analog power.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pstate_reg   <= PS_ON;
      wake_cnt_reg <= 8'h00;
    end else if (clk_en_in) begin
      case (pstate_reg)
        PS_ON: begin
          if (cfg_reg[`AAC_CFG_SLEEP] && !conv_busy_out) begin
            pstate_reg <= PS_OFF;
          end else if (eoc && !cnv_s2_reg) begin
            pstate_reg <= PS_OFF;
          end
        end
        PS_OFF: begin
          if (!cfg_reg[`AAC_CFG_SLEEP] && cnv_rise) begin
            pstate_reg   <= PS_WAKE;
            wake_cnt_reg <= 8'h00;
          end
        end
        PS_WAKE: begin
          if (cfg_reg[`AAC_CFG_SLEEP]) begin
            pstate_reg <= PS_OFF;
          end else if (wake_cnt_reg == PWRUP_CYC - 8'h01) begin
            pstate_reg <= PS_ON;
          end else begin
            wake_cnt_reg <= wake_cnt_reg + 8'h01;
          end
        end
        default: pstate_reg <= PS_ON;
      endcase
    end
  end
  // Power enables toward the analog section.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      analog_power_out <= 1'b1;
      ref_power_out    <= 1'b0;
    end else if (clk_en_in) begin
      analog_power_out <= (pstate_reg != PS_OFF);
      ref_power_out    <= cfg_reg[`AAC_CFG_REF];
    end
  end

  // ***************************************************************
  // Alert detection
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_alert
      // The limits are 9 bits wide, so they compare against the top bits of the result.
      aac_chan_alert u_alert (
        .mclk_in     (mclk_in),
        .rst_in      (rst_in),
        .ce_in       (clk_en_in),
        .eval_in     (eoc && (sample_chan_out == g)),
        .value_in    (sample_data_in[11:3]),
        .upper_in    (hi_reg[g]),
        .lower_in    (lo_reg[g]),
        .hyst_in     (hyst_reg[g]),
        .latch_in    (cfg_reg[`AAC_CFG_LATCH]),
        .clear_in    (alert_rd_clr),
        .hi_flag_out (alert_flags[2*g+1]),
        .lo_flag_out (alert_flags[2*g])
      );
    end
  endgenerate
  // ***************************************************************
  // Multi-function pin and serial result output
  // ***************************************************************
  reg  [15:0] shift_reg;
  wire        alert_active;
  wire        pin_level;
  assign alert_active = cfg_reg[`AAC_CFG_AEN] && !cfg_reg[`AAC_CFG_BUSY] && alert_any;
  assign pin_level    = cfg_reg[`AAC_CFG_POL] ? alert_active : !alert_active;
  // Open drain only pulls low, which lets active-low alerts of several parts share one wire.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      multi_function_output_pin_out      <= 1'b0;
      multi_function_output_pin_oe_n_out <= 1'b1;
    end else if (clk_en_in) begin
      if (cfg_reg[`AAC_CFG_DRIVE]) begin
        multi_function_output_pin_out      <= pin_level;
        multi_function_output_pin_oe_n_out <= 1'b0;
      end else begin
        multi_function_output_pin_out      <= 1'b0;
        multi_function_output_pin_oe_n_out <= pin_level;
      end
    end
  end
  // The word is loaded at chip-select fall and advances on each SCLK fall while chip select is low.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_reg    <= 16'h0000;
      sdo_out      <= 1'b0;
      sdo_oe_n_out <= 1'b1;
    end else if (clk_en_in) begin
      if (cs_fall) begin
        shift_reg <= result_word;
      end else if (!cs_s2_reg && sclk_fall) begin
        shift_reg <= {shift_reg[14:0], 1'b0};
      end
      sdo_out      <= cs_fall ? result_word[15] : shift_reg[15];
      sdo_oe_n_out <= cs_s2_reg;
    end
  end
endmodule // aac_top

// >>> aac_sva.sv
// Port-level assertions for the converter alert and power control block.
`timescale 1ns/1ps
module aac_sva (
  input wire        mclk_in,
  input wire        rst_in,
  input wire        conversion_start_n_in,
  input wire        cs_n_in,
  input wire [5:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire        avs_waitrequest_out,
  input wire        analog_power_out,
  input wire        ref_power_out,
  input wire        init_done_out,
  input wire        conv_busy_out,
  input wire        sdo_oe_n_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [6:0] busy_cnt_reg;
  logic       ref_wr_reg;
  wire        acc_cfg = avs_write_in && !avs_waitrequest_out && avs_address_in == 6'h02;

  // Busy length and the last written reference bit, so that the checks
  // below can use exact figures instead of a one-cycle echo.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_cnt_reg <= 7'h00;
      ref_wr_reg   <= 1'b0;
    end else begin
      busy_cnt_reg <= conv_busy_out ? busy_cnt_reg + 7'h01 : 7'h00;
      if (acc_cfg)
        ref_wr_reg <= avs_writedata_in[0];
    end
  end

  a_bus_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");
  a_busy_sixty: assert property ($fell(conv_busy_out) |-> busy_cnt_reg == 7'h3C)
    else $error("conversion length wrong");
  a_busy_gated: assert property ($rose(conv_busy_out) |-> init_done_out && analog_power_out)
    else $error("conversion while not ready");
  a_init_sticky: assert property (init_done_out |=> init_done_out)
    else $error("init flag dropped");
  a_sdo_released: assert property (cs_n_in [*5] |-> sdo_oe_n_out)
    else $error("output driven while deselected");
  a_sdo_driven: assert property (!cs_n_in [*5] |-> !sdo_oe_n_out)
    else $error("output not driven in frame");
  a_ref_follows: assert property (acc_cfg |-> ##[1:2] ref_power_out == ref_wr_reg)
    else $error("reference power wrong");
  a_eoc_power: assert property ($fell(conv_busy_out) && !conversion_start_n_in
      && $past(conversion_start_n_in, 4) == 1'b0 |-> ##[0:2] !analog_power_out)
    else $error("power kept with start pin low");
endmodule // aac_sva

// >>> aac_host_model.sv
// Host model: drives the start pin and reads result words over the serial link.
`timescale 1ns/1ps
module aac_host_model (
  input  wire  mclk_in,
  input  wire  sdo_in,
  input  wire  sdo_oe_n_in,
  output logic conv_start_n_out,
  output logic sclk_out,
  output logic cs_n_out
);
  // Idle levels; the serial clock stands still low between frames.
  initial begin
    conv_start_n_out = 1'b1;
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
  end

  // One start pulse, then a gap; callers keep the low time under the
  // conversion time unless they mean the part to power down.
  task automatic start_pulse(input int low_cyc, input int gap_cyc);
    conv_start_n_out <= 1'b0;
    repeat (low_cyc) @(posedge mclk_in);
    conv_start_n_out <= 1'b1;
    repeat (gap_cyc) @(posedge mclk_in);
  endtask

  // Mode 0 frame at 160 ns per bit; a bit seen while released is unknown.
  task automatic read_word(output logic [15:0] w);
    cs_n_out <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      repeat (8) @(posedge mclk_in);
      w[i] = sdo_oe_n_in ? 1'bx : sdo_in;
      sclk_out <= 1'b1;
      repeat (8) @(posedge mclk_in);
      sclk_out <= 1'b0;
    end
    repeat (8) @(posedge mclk_in);
    cs_n_out <= 1'b1;
  endtask
endmodule // aac_host_model

// >>> aac_top_bench.sv
// Self-checking bench for the converter alert and power control block.
`timescale 1ns/1ps
module aac_top_bench;
  logic        mclk_in;
  logic        rst_in;
  logic [11:0] sample_data_in;
  logic [5:0]  avs_address_in;
  logic        avs_read_in;
  logic        avs_write_in;
  logic [31:0] avs_writedata_in;
  logic        clk_en_in;
  wire  [31:0] avs_readdata_out;
  wire  [1:0]  sample_chan_out;
  wire         avs_waitrequest_out, conversion_start_n_in, sclk_in, cs_n_in, sdo_out, sdo_oe_n_out;
  wire         analog_power_out, ref_power_out, init_done_out, conv_busy_out;
  wire         multi_function_output_pin_out, multi_function_output_pin_oe_n_out;
  wire         pin_line = multi_function_output_pin_oe_n_out ? 1'b1 : multi_function_output_pin_out;
  int          fails, n_compared, seed;
  logic [1:0]  ch;
  logic [8:0]  up, lo;
  logic [11:0] d;
  logic [15:0] w;
  logic [31:0] q;
  logic [5:0]  ra [7] = '{6'h02, 6'h08, 6'h0C, 6'h10, 6'h3F, 6'h04, 6'h03};
  logic [31:0] rv [7] = '{32'h0, 32'h1FF, 32'h0, 32'h1FF, 32'h0, 32'h2, 32'h0};

  aac_host_model host_u (.mclk_in(mclk_in), .sdo_in(sdo_out), .sdo_oe_n_in(sdo_oe_n_out),
    .conv_start_n_out(conversion_start_n_in), .sclk_out(sclk_in), .cs_n_out(cs_n_in));
  aac_top dut_u (.*);

  // Free-running 100 MHz clock.
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // One Avalon transfer held until waitrequest is low at a rising edge;
  // an idle cycle follows so the next request never lands in the same step.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd);
    int k;
    avs_address_in   <= a;
    avs_writedata_in <= wd;
    avs_write_in     <= wr;
    avs_read_in      <= !wr;
    k = 0;
    do begin
      @(posedge mclk_in);
      k++;
    end while (avs_waitrequest_out !== 1'b0 && k < 20);
    if (avs_waitrequest_out !== 1'b0) begin
      fails++;
      wrap_up();
    end
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    @(posedge mclk_in);
  endtask

  // Pin level is read mid-cycle, after the registered output has settled.
  task automatic pin_chk(input logic e);
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in);
    chk(pin_line, e);
    @(posedge mclk_in);
  endtask

  function automatic logic [31:0] word(input logic [1:0] c, input logic al, input logic [11:0] v);
    return {17'h0, c, al, v};
  endfunction

  task automatic conv(input logic [8:0] v, input logic al, input int lc);
    d = {v, 3'($urandom)};
    sample_data_in <= d;
    host_u.start_pulse(lc, 90);
    host_u.read_word(w);
    chk({16'h0, w}, word(ch, al, d));
  endtask

  initial begin
    fails = 0;
    n_compared = 0;
    rst_in = 1'b1;
    clk_en_in = 1'b1;
    sample_data_in = 12'h000;
    avs_address_in = 6'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    seed = $urandom(56109);
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk(q, rv[i]);
    end
    pin_chk(1'b1);
    $display("reset test done");
    // A pulse sent while the clock enable is low must not count toward the train.
    clk_en_in <= 1'b0;
    host_u.start_pulse(10, 205);
    clk_en_in <= 1'b1;
    // Pulse seven follows its predecessor too closely and must not count.
    for (int i = 0; i < 67; i++) begin
      if (i == 66) chk(init_done_out, 1'b0);
      host_u.start_pulse(10, i == 5 ? 30 : 205);
    end
    chk(init_done_out, 1'b1);
    $display("init test done");
    ch = 2'($urandom);
    up = 9'h096 + 9'($urandom % 200);
    lo = up - 9'h050;
    bus(1'b1, 6'h02, 32'h211);
    bus(1'b1, 6'h01, ch);
    bus(1'b1, 6'h08 + ch, up);
    bus(1'b1, 6'h0C + ch, lo);
    bus(1'b1, 6'h10 + ch, 32'hFE10);
    bus(1'b0, 6'h10 + ch, 32'h0);
    chk(q, 32'h10);
    bus(1'b0, 6'h04, 32'h0);
    chk(q, 32'h7);
    repeat (3) conv(lo + 9'($urandom % 80), 1'b0, 20);
    conv(up + 9'h005, 1'b1, 20);
    pin_chk(1'b0);
    conv(up - 9'h00A, 1'b1, 20);
    pin_chk(1'b0);
    conv(up - 9'h014, 1'b0, 20);
    pin_chk(1'b1);
    conv(up + 9'h005, 1'b1, 20);
    bus(1'b0, 6'h03, 32'h0);
    chk(q, 32'h1 << (2 * ch + 1));
    pin_chk(1'b1);
    conv(lo - 9'h003, 1'b1, 20);
    bus(1'b0, 6'h03, 32'h0);
    chk(q, 32'h1 << (2 * ch));
    $display("alert test done");
    bus(1'b1, 6'h02, 32'h002);
    repeat (5) @(posedge mclk_in);
    bus(1'b0, 6'h04, 32'h0);
    chk(q, 32'h1);
    host_u.read_word(w);
    chk({16'h0, w}, word(ch, 1'b0, d));
    bus(1'b1, 6'h02, 32'h011);
    // Wake pulse with a shortened settling wait; reference settling only affects accuracy.
    host_u.start_pulse(10, 120);
    conv(lo + 9'h005, 1'b0, 20);
    conv(lo + 9'h006, 1'b0, 90);
    $display("power test done");
    bus(1'b1, 6'h02, 32'h091);
    conv(up + 9'h005, 1'b1, 20);
    conv(lo + 9'h028, 1'b1, 20);
    pin_chk(1'b0);
    bus(1'b1, 6'h02, 32'h291);
    pin_chk(1'b1);
    bus(1'b1, 6'h02, 32'h059);
    pin_chk(1'b0);
    conv(up + 9'h005, 1'b1, 20);
    pin_chk(1'b1);
    bus(1'b1, 6'h02, 32'h079);
    pin_chk(1'b0);
    $display("latch and pin test done");
    wrap_up();
  end
endmodule // aac_top_bench

bind aac_top aac_sva sva_u (.*);
